// ===== timer2_pkg.sv
`default_nettype none
package timer2_pkg;
  localparam logic [7:0] CTRL_OFS = 8'hB0;
  localparam logic [7:0] CNT_OFS = 8'hB2;
  localparam logic [7:0] CMP_OFS = 8'hB3;
  localparam logic [7:0] STAT_OFS = 8'hB6;
  localparam logic [7:0] MASK_OFS = 8'h70;
  localparam logic [7:0] FLAG_OFS = 8'h37;
  localparam logic [7:0] GTC_OFS = 8'h43;
  localparam logic [7:0] RST_VAL = 8'h00;
  localparam int EXT_BIT = 4;
  localparam int ASEL_BIT = 3;
  localparam int CNT_IDX = 2;
  localparam int CMP_IDX = 1;
  localparam int CTL_IDX = 0;
  localparam int CMP_F = 1;
  localparam int OVF_F = 0;
  localparam int PSR_BIT = 1;
  localparam int WGM0_BIT = 6;
  localparam int WGM1_BIT = 3;
  localparam int HALT_CYC = 4;
  localparam logic [7:0] CTL_WMASK = 8'h7F;
  typedef enum logic [1:0] {
    X_IDLE = 2'b00,
    X_WAIT = 2'b01,
    X_HALF = 2'b11
  } xfer_t;
endpackage
`default_nettype wire

// ===== timer2_async.sv
`default_nettype none
module timer2_async import timer2_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // processor side
  input wire logic global_irq_enable,
  input wire logic compare_vector_ack,
  input wire logic overflow_vector_ack,
  input wire logic sleep_active,
  input wire logic osc_stop_mode,
  output logic compare_irq_req,
  output logic overflow_irq_req,
  output logic wake_req,
  output logic cpu_halt,
  // pins
  input wire logic timer_osc_in,
  output logic xtal_osc_enable,
  output logic ext_buf_enable,
  output logic osc_pins_released,
  output logic compare_output_pin
);
  logic [7:0] cnt_reg, cmp_reg, ctl_reg, hold_reg;
  logic [7:0] tmp_reg [3];
  xfer_t xs_reg [3];
  logic ext_reg, asel_reg, psr_reg, up_reg, blk_reg;
  logic [1:0] ie_reg, flag_reg, cpipe_reg, opipe_reg;
  logic [1:0] osc_sync_reg, lock_reg;
  logic osc_last_reg, wk_pend_reg;
  logic [9:0] pre_reg;
  logic [HALT_CYC-1:0] halt_reg;

  function automatic logic [9:0] div_mask(input logic [2:0] cs);
    case (cs)
      3'h2: div_mask = 10'h007;
      3'h3: div_mask = 10'h01F;
      3'h4: div_mask = 10'h03F;
      3'h5: div_mask = 10'h07F;
      3'h6: div_mask = 10'h0FF;
      3'h7: div_mask = 10'h3FF;
      default: div_mask = 10'h000;
    endcase
  endfunction

  // decode and shared terms
  logic [2:0] wr_sel, busy, done;
  logic tsrc_tick, cnt_tick, psr_fire, match_ev, ovf_ev, pc_mode;
  logic [1:0] wgm, com, flag_set, flag_clr;
  assign wr_sel = {wr_en && addr == CNT_OFS, wr_en && addr == CMP_OFS,
                   wr_en && addr == CTRL_OFS};
  assign wgm = {ctl_reg[WGM1_BIT], ctl_reg[WGM0_BIT]};
  assign com = ctl_reg[5:4];
  assign pc_mode = wgm == 2'h1;
  // timer edge from the synchronised pin, or every io cycle
  assign tsrc_tick = asel_reg ? (osc_sync_reg[1] && !osc_last_reg) : 1'b1;
  assign cnt_tick = tsrc_tick && ctl_reg[2:0] != 3'h0 &&
                    (pre_reg & div_mask(ctl_reg[2:0])) == div_mask(ctl_reg[2:0]);
  assign psr_fire = psr_reg && (!asel_reg || tsrc_tick);
  assign match_ev = cnt_tick && cnt_reg == cmp_reg && !busy[CMP_IDX] &&
                    !busy[CNT_IDX] && !blk_reg;
  assign ovf_ev = cnt_tick && (pc_mode ? (!up_reg && cnt_reg == 8'h00)
                                       : cnt_reg == 8'hFF);
  assign flag_set = asel_reg ? {cpipe_reg[1], opipe_reg[1]} : {match_ev, ovf_ev};
  assign flag_clr = ({2{wr_en && addr == FLAG_OFS}} & wdata[1:0]) |
                    {compare_vector_ack, overflow_vector_ack};
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      busy[i] = xs_reg[i] != X_IDLE;
      done[i] = xs_reg[i] == X_HALF && tsrc_tick && !(wr_sel[i] && asel_reg);
    end
  end

  // two-flop pin synchroniser; only the second stage feeds edge logic
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      osc_sync_reg <= 2'h0;
      osc_last_reg <= 1'b0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[0], timer_osc_in};
      osc_last_reg <= osc_sync_reg[1];
    end
  end

  // transfer sequencer per register; a rewrite restarts its own only
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (srst) begin
        xs_reg[i] <= X_IDLE;
        tmp_reg[i] <= RST_VAL;
      end else begin
        if (wr_sel[i]) begin
          tmp_reg[i] <= (i == CTL_IDX) ? (wdata & CTL_WMASK) : wdata;
        end
        if (wr_sel[i] && asel_reg) begin
          xs_reg[i] <= X_WAIT;
        end else if (tsrc_tick) begin
          case (xs_reg[i])
            X_WAIT: xs_reg[i] <= X_HALF;
            X_HALF: xs_reg[i] <= X_IDLE;
            default: xs_reg[i] <= X_IDLE;
          endcase
        end
      end
    end
  end

  // compare and control destinations
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmp_reg <= RST_VAL;
      ctl_reg <= RST_VAL;
    end else begin
      if (wr_sel[CMP_IDX] && !asel_reg) begin
        cmp_reg <= wdata;
      end else if (done[CMP_IDX]) begin
        cmp_reg <= tmp_reg[CMP_IDX];
      end
      if (wr_sel[CTL_IDX] && !asel_reg) begin
        ctl_reg <= wdata & CTL_WMASK;
      end else if (done[CTL_IDX]) begin
        ctl_reg <= tmp_reg[CTL_IDX];
      end
    end
  end

  // counter, direction and match blocking after a counter load
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_reg <= RST_VAL;
      up_reg <= 1'b1;
      blk_reg <= 1'b0;
    end else if ((wr_sel[CNT_IDX] && !asel_reg) || done[CNT_IDX]) begin
      cnt_reg <= asel_reg ? tmp_reg[CNT_IDX] : wdata;
      blk_reg <= 1'b1;
    end else if (cnt_tick) begin
      blk_reg <= 1'b0;
      if (pc_mode) begin
        if (up_reg && cnt_reg == 8'hFF) begin
          up_reg <= 1'b0;
          cnt_reg <= cnt_reg - 8'h01;
        end else if (!up_reg && cnt_reg == 8'h00) begin
          up_reg <= 1'b1;
          cnt_reg <= 8'h01;
        end else begin
          cnt_reg <= up_reg ? cnt_reg + 8'h01 : cnt_reg - 8'h01;
        end
      end else if (wgm == 2'h2 && cnt_reg == cmp_reg) begin
        cnt_reg <= 8'h00;
      end else begin
        up_reg <= 1'b1;
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  // holding register: only moves on timer edges in async mode
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hold_reg <= RST_VAL;
    end else if (tsrc_tick) begin
      hold_reg <= cnt_reg;
    end
  end

  // prescaler; async reset request waits for a real timer edge
  always_ff @(posedge ref_clk) begin
    if (srst || psr_fire) begin
      pre_reg <= 10'h000;
    end else if (tsrc_tick) begin
      pre_reg <= pre_reg + 10'h001;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      psr_reg <= 1'b0;
    end else if (wr_en && addr == GTC_OFS && wdata[PSR_BIT]) begin
      psr_reg <= 1'b1;
    end else if (psr_fire) begin
      psr_reg <= 1'b0;
    end
  end

  // compare output on the timer tick itself, no cpu sync
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      compare_output_pin <= 1'b0;
    end else if (match_ev) begin
      case (wgm)
        2'h1: compare_output_pin <= (com == 2'h3) == up_reg;
        2'h3: compare_output_pin <= com == 2'h3;
        default: compare_output_pin <= com == 2'h1 ? !compare_output_pin : com == 2'h3;
      endcase
    end else if (ovf_ev && wgm == 2'h3 && com[1]) begin
      compare_output_pin <= com == 2'h2;
    end
  end

  // flag crossing: event tick, then two more io cycles into the flag
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cpipe_reg <= 2'h0;
      opipe_reg <= 2'h0;
    end else begin
      cpipe_reg <= {cpipe_reg[0], match_ev && asel_reg};
      opipe_reg <= {opipe_reg[0], ovf_ev && asel_reg};
    end
  end

  // sticky flags; a set in the clear cycle wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flag_reg <= 2'h0;
    end else begin
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
    end
  end

  // mask, clock select and interrupt requests
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ie_reg <= 2'h0;
      ext_reg <= 1'b0;
      asel_reg <= 1'b0;
      compare_irq_req <= 1'b0;
      overflow_irq_req <= 1'b0;
    end else begin
      if (wr_en && addr == MASK_OFS) begin
        ie_reg <= wdata[1:0];
      end
      if (wr_en && addr == STAT_OFS) begin
        ext_reg <= wdata[EXT_BIT];
        asel_reg <= wdata[ASEL_BIT];
      end
      compare_irq_req <= ie_reg[CMP_F] && global_irq_enable && flag_reg[CMP_F];
      overflow_irq_req <= ie_reg[OVF_F] && global_irq_enable && flag_reg[OVF_F];
    end
  end

  // oscillator and pin control; sleep modes that kill the clock stop it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      xtal_osc_enable <= 1'b0;
      ext_buf_enable <= 1'b0;
      osc_pins_released <= 1'b0;
    end else begin
      xtal_osc_enable <= asel_reg && !ext_reg && !osc_stop_mode;
      ext_buf_enable <= asel_reg && ext_reg;
      osc_pins_released <= asel_reg;
    end
  end

  // wake: pending condition fires on the next timer edge, then lockout
  logic irq_cond, wk_fire;
  assign irq_cond = global_irq_enable && |(flag_reg & ie_reg);
  assign wk_fire = wk_pend_reg && tsrc_tick;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wk_pend_reg <= 1'b0;
      wake_req <= 1'b0;
      lock_reg <= 2'h0;
      halt_reg <= '0;
    end else begin
      wk_pend_reg <= sleep_active && irq_cond && lock_reg == 2'h0 && !wk_fire;
      if (wk_fire) begin
        wake_req <= 1'b1;
        lock_reg <= 2'h2;
        halt_reg <= {HALT_CYC{1'b1}};
      end else begin
        if (!sleep_active) begin
          wake_req <= 1'b0;
        end
        if (tsrc_tick && lock_reg != 2'h0) begin
          lock_reg <= lock_reg - 2'h1;
        end
        halt_reg <= halt_reg >> 1;
      end
    end
  end
  assign cpu_halt = halt_reg[0];

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (srst || !rd_en) begin
      rdata <= RST_VAL;
    end else begin
      case (addr)
        CNT_OFS: rdata <= asel_reg ? hold_reg : cnt_reg;
        CMP_OFS: rdata <= tmp_reg[CMP_IDX];
        CTRL_OFS: rdata <= tmp_reg[CTL_IDX];
        STAT_OFS: rdata <= {3'h0, ext_reg, asel_reg, busy};
        MASK_OFS: rdata <= {6'h00, ie_reg};
        FLAG_OFS: rdata <= {6'h00, flag_reg};
        GTC_OFS: rdata <= {6'h00, psr_reg, 1'b0};
        default: rdata <= RST_VAL;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_busy_on_write: assert property (wr_sel[CNT_IDX] && asel_reg |=> busy[CNT_IDX])
    else $error("counter busy not set");
  a_xfer_copies: assert property (done[CMP_IDX] |=> cmp_reg == $past(tmp_reg[CMP_IDX]))
    else $error("compare transfer wrong");
  a_ctl_read_temp: assert property (rd_en && addr == CTRL_OFS |=> rdata == $past(tmp_reg[CTL_IDX]))
    else $error("control read not temp");
  a_match_needs_idle: assert property (match_ev |-> xs_reg[CMP_IDX] == X_IDLE && !blk_reg)
    else $error("match while pending");
  a_flag_latency: assert property (asel_reg && match_ev |-> ##3 flag_reg[CMP_F] || !asel_reg)
    else $error("flag latency wrong");
  a_cmp_request: assert property (ie_reg[CMP_F] && global_irq_enable && flag_reg[CMP_F] |=> compare_irq_req)
    else $error("compare request missing");
  a_ovf_request: assert property (!ie_reg[OVF_F] |=> !overflow_irq_req)
    else $error("overflow request unmasked");
  a_psr_hold: assert property (psr_reg && asel_reg && !tsrc_tick |=> psr_reg)
    else $error("prescaler reset cleared early");
  a_halt_four: assert property ($rose(wake_req) |-> cpu_halt [*4] ##1 !cpu_halt)
    else $error("halt not four cycles");
endmodule
`default_nettype wire

// ===== timer_osc_model.sv
`default_nettype none
module timer_osc_model #(
  parameter int HALF_NS = 50
) (
  // control
  input wire logic run,
  // pin
  output logic timer_osc_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // slow source: keeps the cpu clock well over four times faster
  logic phase = 1'b0;

  // a stopped crystal stands still low rather than holding a stale phase
  always #(HALF_NS) phase = run && !phase;
  assign timer_osc_in = phase;
endmodule
`default_nettype wire

// ===== async_timer2_clock_domain_bench.sv
`default_nettype none
module async_timer2_clock_domain_bench import timer2_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic global_irq_enable = 1'b0;
  logic compare_vector_ack = 1'b0;
  logic overflow_vector_ack = 1'b0;
  logic sleep_active = 1'b0;
  logic osc_stop_mode = 1'b0;
  logic [7:0] rdata;
  logic compare_irq_req, overflow_irq_req, wake_req, cpu_halt;
  logic timer_osc_in, xtal_osc_enable, ext_buf_enable, osc_pins_released, compare_output_pin;
  int miscompares = 0;
  int total_checks = 0;
  int mask_m, cmp_m, n, m;
  int divs[6] = '{8, 32, 64, 128, 256, 1024};
  logic [7:0] v, w;

  timer2_async u_timer2_async (.ref_clk, .srst, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .global_irq_enable, .compare_vector_ack, .overflow_vector_ack, .sleep_active, .osc_stop_mode,
    .compare_irq_req, .overflow_irq_req, .wake_req, .cpu_halt, .timer_osc_in, .xtal_osc_enable,
    .ext_buf_enable, .osc_pins_released, .compare_output_pin);
  // timer period is twenty io cycles
  // the pin only toggles while the design lets the oscillator run
  timer_osc_model #(.HALF_NS(50)) u_timer_osc_model (.run(xtal_osc_enable || ext_buf_enable), .timer_osc_in);

  always #2.5 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle strobes, launched right after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask

  // polls status until a busy bit drops; cyc counts two-cycle reads
  task automatic wait_idle(input int bi, output int cyc);
    logic [7:0] d;
    cyc = 0;
    rd(STAT_OFS, d);
    while (d[bi] === 1'b1 && cyc < 100) begin
      rd(STAT_OFS, d);
      cyc++;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial begin
    void'($urandom(32'hD722B472));
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    rchk("status reset", STAT_OFS, RST_VAL);
    rchk("mask reset", MASK_OFS, RST_VAL);
    wr(8'hC5, 8'hFF);
    rchk("unmapped", 8'hC5, 8'h00);
    mask_m = $urandom() & 32'hFF;
    wr(MASK_OFS, 8'(mask_m));
    rchk("mask rw", MASK_OFS, 8'(mask_m & 3));
    cmp_m = $urandom_range(200, 20);
    wr(CMP_OFS, 8'(cmp_m));
    wr(CTRL_OFS, 8'h81);
    rchk("cmp sync", CMP_OFS, 8'(cmp_m));
    rchk("ctl sync", CTRL_OFS, 8'h01);
    rchk("no busy sync", STAT_OFS, 8'h00);
    $display("test registers done");
    // stopped, undivided and every prescaler tap
    wr(CTRL_OFS, 8'h00);
    rd(CNT_OFS, v);
    repeat (20) @(posedge ref_clk);
    rchk("stopped", CNT_OFS, v);
    wr(CTRL_OFS, 8'h01);
    rd(CNT_OFS, v);
    repeat (30) @(posedge ref_clk);
    rchk("undivided", CNT_OFS, 8'(v + 32));
    foreach (divs[i]) begin
      wr(CTRL_OFS, 8'(i + 2));
      rd(CNT_OFS, v);
      repeat (1022) @(posedge ref_clk);
      rchk("divided", CNT_OFS, 8'(v + 1024 / divs[i]));
    end
    wr(GTC_OFS, 8'h02);
    repeat (3) @(posedge ref_clk);
    rchk("psr sync", GTC_OFS, 8'h00);
    $display("test prescaler done");
    // compare and overflow requests, vector and write-one clears
    wr(CTRL_OFS, 8'h00);
    wr(CNT_OFS, 8'h00);
    wr(FLAG_OFS, 8'h03);
    wr(MASK_OFS, 8'h02);
    global_irq_enable <= 1'b1;
    // undivided, normal mode, pin toggles on each match
    wr(CTRL_OFS, 8'h11);
    n = 0;
    while (compare_irq_req !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("cmp req", 8'h01, {7'h00, compare_irq_req});
    chk("pin toggle", 8'h01, {7'h00, compare_output_pin});
    rchk("cmp flag", FLAG_OFS, 8'h02);
    @(posedge ref_clk);
    compare_vector_ack <= 1'b1;
    @(posedge ref_clk);
    compare_vector_ack <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("cmp ack", 8'h00, {7'h00, compare_irq_req});
    repeat (300) @(posedge ref_clk);
    rchk("both flags", FLAG_OFS, 8'h03);
    chk("ovf masked", 8'h00, {7'h00, overflow_irq_req});
    wr(MASK_OFS, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1 chk("ovf req", 8'h01, {7'h00, overflow_irq_req});
    wr(FLAG_OFS, 8'h01);
    rd(FLAG_OFS, v);
    chk("ovf w1c", 8'h00, {7'h00, v[0]});
    $display("test flags done");
    // wake from sleep on overflow, then a four-cycle halt
    sleep_active <= 1'b1;
    n = 0;
    while (wake_req !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("wake", 8'h01, {7'h00, wake_req});
    m = 0;
    // woken cpu leaves sleep at once, so the lockout is not re-armed
    repeat (8) begin
      m += int'(cpu_halt === 1'b1);
      @(posedge ref_clk);
      sleep_active <= 1'b0;
      #1;
    end
    chk("halt cycles", 8'(HALT_CYC), 8'(m));
    @(posedge ref_clk);
    sleep_active <= 1'b0;
    global_irq_enable <= 1'b0;
    $display("test wake done");
    // asynchronous clocking and the pin enables
    wr(MASK_OFS, 8'h00);
    wr(STAT_OFS, 8'h08);
    repeat (2) @(posedge ref_clk);
    #1 chk("pins released", 8'h01, {7'h00, osc_pins_released});
    chk("crystal on", 8'h01, {7'h00, xtal_osc_enable});
    chk("ext buf off", 8'h00, {7'h00, ext_buf_enable});
    @(posedge ref_clk);
    osc_stop_mode <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk("crystal stopped", 8'h00, {7'h00, xtal_osc_enable});
    @(posedge ref_clk);
    osc_stop_mode <= 1'b0;
    // just above the load value, so a match lands inside the count window
    cmp_m = $urandom_range(73, 68);
    wr(CNT_OFS, 8'h40);
    wr(CMP_OFS, 8'(cmp_m));
    rchk("two busy", STAT_OFS, 8'h0E);
    wait_idle(CMP_IDX, n);
    rchk("busy clear", STAT_OFS, 8'h08);
    rchk("cmp temp", CMP_OFS, 8'(cmp_m));
    wr(CTRL_OFS, 8'h01);
    rchk("ctl busy", STAT_OFS, 8'h09);
    wait_idle(CTL_IDX, n);
    chk("xfer span", 8'h01, 8'(n >= 8 && n < 30));
    wr(FLAG_OFS, 8'h03);
    rd(CNT_OFS, v);
    repeat (198) @(posedge ref_clk);
    rchk("async count", CNT_OFS, 8'(v + 10));
    rchk("async flag", FLAG_OFS, 8'h02);
    @(posedge timer_osc_in);
    repeat (4) @(posedge ref_clk);
    wr(GTC_OFS, 8'h02);
    rchk("psr held", GTC_OFS, 8'h02);
    repeat (25) @(posedge ref_clk);
    rchk("psr done", GTC_OFS, 8'h00);
    $display("test async done");
    conclude();
  end

  // cuts a hang well past the expected run length
  initial begin
    #(40000 * 5);
    miscompares++;
    $display("watchdog expired");
    conclude();
  end
endmodule
`default_nettype wire
